// *** urx_pkg.sv ***
// package: register map, field positions and constants for the uart receiver
package urx_pkg;
    localparam logic [11:0] ADDR_MODE   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_BAUD   = 12'h008;
    localparam logic [11:0] ADDR_RXBUF  = 12'h00c;
    localparam logic [11:0] ADDR_IFLAG  = 12'h010;
    localparam logic [11:0] ADDR_IMASK  = 12'h014;
    localparam int MODE_PARITY_DATA_SELECT_LO = 1;
    localparam int MODE_HS_BIT   = 3;
    localparam int MODE_EN_BIT   = 15;
    localparam int STA_OVR_BIT   = 1;
    localparam int STA_PARITY_ERROR_FLAG_BIT  = 3;
    localparam int STA_FERR_BIT  = 2;
    localparam int STA_AVAIL_BIT = 0;
    localparam int STA_FULL_BIT  = 4;
    localparam int IFL_P1_BIT    = 11;
    localparam int IFL_P2_BIT    = 14;
    localparam logic [1:0] PARITY_DATA_SELECT_EVEN = 2'h1;
    localparam logic [1:0] PARITY_DATA_SELECT_ODD  = 2'h2;
    localparam int LS_DIV = 16;
    localparam int HS_DIV = 4;
    localparam int FIFO_DEPTH = 4;
    localparam logic [15:0] BAUD_RST = 16'h0000;
    localparam logic [15:0] MODE_RST = 16'h0000;
endpackage

// *** urx_top.sv ***
// uart receiver with four-byte fifo, parity check and apb registers
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module urx_top
    import urx_pkg::*;
#(
    parameter int PORT_INDEX = 1
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_line,
    output logic             irq
);
    import urx_pkg::*;

    typedef enum logic [2:0] {URX_IDLE, URX_START, URX_DATA, URX_PAR, URX_STOP} urx_state_e;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0] mode_r;
    logic [15:0] baud_r;
    logic        ovr_r;
    logic        parity_error_flag_r;
    logic        ferr_r;
    logic [15:0] iflag_r;
    logic [15:0] imask_r;
    logic [7:0]  fifo_r [FIFO_DEPTH];
    logic [FIFO_DEPTH-1:0] fperr_r;
    logic [2:0]  count_r;
    logic [1:0]  rd_ptr_r;
    logic [1:0]  wr_ptr_r;
    logic        irq_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        pop_ok_r;

    logic        acc;
    logic        wr_acc;
    logic        rd_acc;
    logic        pop;
    logic        push;
    logic        par_on;
    logic [17:0] bit_cycles;
    localparam int IFL_BIT = (PORT_INDEX == 2) ? IFL_P2_BIT : IFL_P1_BIT;

    // single-cycle access phase; pready rises one cycle after setup
    assign acc    = psel && penable && pready_r;
    assign wr_acc = acc && pwrite;
    assign rd_acc = acc && !pwrite;
    // emptiness judged at setup, when the read data was taken, so a byte
    // landing between setup and access is never popped unseen
    assign pop    = rd_acc && (paddr == ADDR_RXBUF) && pop_ok_r;
    // codes 00 and 11 leave parity off
    assign par_on = (mode_r[MODE_PARITY_DATA_SELECT_LO+:2] == PARITY_DATA_SELECT_EVEN) ||
                    (mode_r[MODE_PARITY_DATA_SELECT_LO+:2] == PARITY_DATA_SELECT_ODD);
    // bit time = (divisor+1) * 16, or * 4 in high-speed mode
    assign bit_cycles = mode_r[MODE_HS_BIT] ?
                        18'({2'h0, baud_r} + 18'h1) << 2 :
                        18'({2'h0, baud_r} + 18'h1) << 4;

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    urx_state_e  st_r;
    logic [17:0] tick_r;
    logic [2:0]  bit_r;
    logic [7:0]  shift_r;
    logic        par_acc_r;
    logic        done;
    logic        done_parity_error_flag;
    logic        done_ferr;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r      <= URX_IDLE;
            tick_r    <= 18'h0;
            bit_r     <= 3'h0;
            shift_r   <= 8'h0;
            par_acc_r <= 1'b0;
        end else if (!mode_r[MODE_EN_BIT]) begin
            st_r <= URX_IDLE;
        end else begin
            case (st_r)
                URX_IDLE: begin
                    if (!rx_line) begin
                        st_r   <= URX_START;
                        // half a bit to land on the start bit centre
                        tick_r <= bit_cycles >> 1;
                    end
                end
                default: begin
                    if (tick_r != 18'h0) begin
                        tick_r <= tick_r - 18'h1;
                    end else begin
                        tick_r <= bit_cycles - 18'h1;
                        case (st_r)
                            URX_START: begin
                                // glitch shorter than half a bit is ignored
                                st_r      <= rx_line ? URX_IDLE : URX_DATA;
                                bit_r     <= 3'h0;
                                par_acc_r <= 1'b0;
                            end
                            URX_DATA: begin
                                shift_r   <= {rx_line, shift_r[7:1]};
                                par_acc_r <= par_acc_r ^ rx_line;
                                bit_r     <= bit_r + 3'h1;
                                if (bit_r == 3'h7) begin
                                    st_r <= par_on ? URX_PAR : URX_STOP;
                                end
                            end
                            URX_PAR: begin
                                par_acc_r <= par_acc_r ^ rx_line;
                                st_r      <= URX_STOP;
                            end
                            default: begin
                                st_r <= URX_IDLE;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // stop bit sampled: byte complete
    assign done = (st_r == URX_STOP) && (tick_r == 18'h0) && mode_r[MODE_EN_BIT];
    // parity from xor of data and parity bit only, independent of divisor
    assign done_parity_error_flag = par_on && (par_acc_r != (mode_r[MODE_PARITY_DATA_SELECT_LO+:2] == PARITY_DATA_SELECT_ODD));
    assign done_ferr = !rx_line;
    // a fifth byte is dropped, fifo content kept; a read in the same cycle makes room
    assign push = done && ((count_r != 3'(FIFO_DEPTH)) || pop);

    // ----------------------------------------------------------------
    // fifo
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_ptr_r <= 2'h0;
            wr_ptr_r <= 2'h0;
            count_r  <= 3'h0;
            fperr_r  <= '0;
        end else begin
            if (push) begin
                fifo_r[wr_ptr_r]  <= shift_r;
                fperr_r[wr_ptr_r] <= done_parity_error_flag;
                wr_ptr_r          <= wr_ptr_r + 2'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 2'h1;
            end
            count_r <= count_r + 3'(push) - 3'(pop);
        end
    end

    // ----------------------------------------------------------------
    // status and interrupt flags, set wins over clear
    // ----------------------------------------------------------------
    logic ovr_set;
    logic full_set;
    assign ovr_set  = done && (count_r == 3'(FIFO_DEPTH)) && !pop;
    assign full_set = push && (count_r == 3'(FIFO_DEPTH - 1)) && !pop;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ovr_r   <= 1'b0;
            parity_error_flag_r  <= 1'b0;
            ferr_r  <= 1'b0;
            iflag_r <= 16'h0;
            imask_r <= 16'h0;
            irq_r   <= 1'b0;
        end else begin
            // write one to clear; hardware set takes precedence
            if (wr_acc && paddr == ADDR_STATUS) begin
                ovr_r  <= ovr_set || (ovr_r && !pwdata[STA_OVR_BIT]);
                parity_error_flag_r <= (push && done_parity_error_flag) || (parity_error_flag_r && !pwdata[STA_PARITY_ERROR_FLAG_BIT]);
                ferr_r <= (push && done_ferr) || (ferr_r && !pwdata[STA_FERR_BIT]);
            end else begin
                ovr_r  <= ovr_r || ovr_set;
                parity_error_flag_r <= parity_error_flag_r || (push && done_parity_error_flag);
                ferr_r <= ferr_r || (push && done_ferr);
            end
            if (wr_acc && paddr == ADDR_IFLAG) begin
                iflag_r[IFL_BIT] <= full_set || (iflag_r[IFL_BIT] && !pwdata[IFL_BIT]);
            end else begin
                iflag_r[IFL_BIT] <= iflag_r[IFL_BIT] || full_set;
            end
            if (wr_acc && paddr == ADDR_IMASK) begin
                imask_r <= pwdata[15:0];
            end
            irq_r <= |(iflag_r & imask_r);
        end
    end

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_r <= MODE_RST;
            baud_r <= BAUD_RST;
        end else if (wr_acc) begin
            if (paddr == ADDR_MODE) begin
                mode_r <= pwdata[15:0];
            end
            if (paddr == ADDR_BAUD) begin
                baud_r <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
            pop_ok_r  <= 1'b0;
        end else begin
            pready_r  <= psel && !penable;
            pop_ok_r  <= psel && !penable && !pwrite &&
                         (paddr == ADDR_RXBUF) && (count_r != 3'h0);
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
            if (psel && !penable) begin
                case (paddr)
                    ADDR_MODE:   prdata_r <= {16'h0, mode_r};
                    ADDR_BAUD:   prdata_r <= {16'h0, baud_r};
                    ADDR_STATUS: begin
                        prdata_r[STA_AVAIL_BIT] <= count_r != 3'h0;
                        prdata_r[STA_OVR_BIT]   <= ovr_r;
                        prdata_r[STA_FERR_BIT]  <= ferr_r;
                        prdata_r[STA_PARITY_ERROR_FLAG_BIT]  <= parity_error_flag_r;
                        prdata_r[STA_FULL_BIT]  <= count_r == 3'(FIFO_DEPTH);
                    end
                    ADDR_RXBUF: begin
                        prdata_r <= {23'h0, fperr_r[rd_ptr_r], fifo_r[rd_ptr_r]};
                    end
                    ADDR_IFLAG:  prdata_r <= {16'h0, iflag_r};
                    ADDR_IMASK:  prdata_r <= {16'h0, imask_r};
                    default:     pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // stop bit centre reached with the receiver on
    sequence s_stop_hit;
        (st_r == URX_STOP) && (tick_r == 18'h0) && mode_r[MODE_EN_BIT];
    endsequence

    // a slot is free, or a read frees one in the same cycle
    sequence s_room_left;
        (count_r != 3'(FIFO_DEPTH)) || pop;
    endsequence

    // fifo full and no read under way
    sequence s_no_room;
        (count_r == 3'(FIFO_DEPTH)) && !pop;
    endsequence

    // a data bit sampled in high-speed mode
    sequence s_hs_sample;
        (st_r == URX_DATA) && (tick_r == 18'h0) && mode_r[MODE_HS_BIT] && mode_r[MODE_EN_BIT];
    endsequence

    // no status write that could clear a flag
    sequence s_no_sta_wr;
        !(wr_acc && (paddr == ADDR_STATUS));
    endsequence

    a_fifo_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
        count_r <= 3'(FIFO_DEPTH)) else $error("fifo count exceeds depth");

    a_full_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        full_set |=> count_r == 3'(FIFO_DEPTH))
        else $error("fourth byte did not fill the fifo");

    a_ovr_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(ovr_r) |-> $past(done) && $past(count_r) == 3'(FIFO_DEPTH))
        else $error("overrun set without fifth byte");

    a_ovr_fifth: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_stop_hit ##0 s_no_room |=> ovr_r)
        else $error("fifth byte did not flag overrun");

    a_full_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        full_set |=> iflag_r[IFL_BIT]) else $error("rx flag not set on full");

    a_flag_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(iflag_r[IFL_BIT]) |-> count_r == 3'(FIFO_DEPTH))
        else $error("rx flag raised before fifo full");

    a_pop_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pop && !push |=> count_r == $past(count_r) - 3'h1)
        else $error("read did not pop one byte");

    a_pop_empty: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pop |-> count_r != 3'h0) else $error("pop from empty fifo");

    a_ovr_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ovr_r ##0 s_no_sta_wr |=> ovr_r)
        else $error("overrun dropped without clear");

    a_parity_error_flag_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
        push && done_parity_error_flag |=> parity_error_flag_r) else $error("parity error not flagged");

    a_par_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        push && !par_on ##0 s_no_sta_wr |=> parity_error_flag_r == $past(parity_error_flag_r))
        else $error("parity checked while disabled");

    a_hs_time: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_hs_sample |=> tick_r == (18'($past(baud_r)) << 2) + 18'h3)
        else $error("high speed bit time wrong");

    a_stop_push: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_stop_hit ##0 s_room_left |=> count_r == $past(count_r) + 3'h1 - 3'($past(pop)))
        else $error("byte not stored after stop bit");

    // irq lags the flags by one register stage
    a_irq_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##1 irq == $past(|(iflag_r & imask_r))) else $error("irq mismatch");
endmodule

// *** urx_tx_model.sv ***
// serial transmitter model driving the receive line
`timescale 1ns/1ps
// ----------------------------------------------------------------
// transmitter model
// ----------------------------------------------------------------
module urx_tx_model (
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [7:0]  data,
    input  wire logic [1:0]  pmode,
    input  wire logic        flip,
    input  wire logic [15:0] bit_cyc,
    output logic             rx_line,
    output logic             busy
);
    logic [10:0] frame;
    int          nbits;
    initial begin
        rx_line = 1'b1;
        busy    = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (go) begin
                nbits = (pmode == 2'h1 || pmode == 2'h2) ? 11 : 10;
                // flip forces a wrong parity bit on purpose
                frame = {1'b1, (pmode == 2'h2) ^ flip ^ (^data), data, 1'b0};
                if (nbits == 10) begin
                    frame[9] = 1'b1;
                end
                busy <= 1'b1;
                for (int i = 0; i < nbits; i++) begin
                    rx_line <= frame[i];
                    repeat (bit_cyc) @(posedge clk_sys);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// *** test_uart_receive_fifo_parity.sv ***
// self-checking bench for the uart receiver
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_uart_receive_fifo_parity;
    import urx_pkg::*;
    typedef struct packed {
        logic [1:0] code;
        logic       hs;
        logic [3:0] baud;
        logic [7:0] data;
        logic       flip;
        logic       parity_error_flag;
    } urx_row_s;
    logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, rx_line, irq;
    logic        go, flip, busy, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  sdata;
    logic [1:0]  pmode;
    logic [15:0] bit_cyc;
    int          n_fail, num_checks;
    urx_row_s    rows [8];

    urx_top i_urx_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_line(rx_line), .irq(irq));
    urx_tx_model i_urx_tx_model (.clk_sys(clk_sys), .go(go), .data(sdata), .pmode(pmode),
        .flip(flip), .bit_cyc(bit_cyc), .rx_line(rx_line), .busy(busy));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // pready, read data and error taken at the rising edge that ends the access
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin n_fail++; wrap_up(); end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(input logic [1:0] c, input logic h, input logic [3:0] b);
        apb(1'b1, ADDR_MODE, 32'h8000 | (32'(h) << MODE_HS_BIT) | (32'(c) << MODE_PARITY_DATA_SELECT_LO));
        apb(1'b1, ADDR_BAUD, 32'(b));
        pmode <= c;
        bit_cyc <= 16'((b + 1) * (h ? HS_DIV : LS_DIV));
    endtask
    task automatic send(input logic [7:0] d, input logic f);
        int n;
        @(posedge clk_sys);
        sdata <= d;
        flip <= f;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (busy !== 1'b0 && n < 3000);
        if (busy !== 1'b0) begin n_fail++; wrap_up(); end
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic irq_is(input logic x);
        repeat (2) @(negedge clk_sys);
        `CHK("irq", x, irq)
    endtask
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, go, flip, sdata, pmode} = '0;
        bit_cyc = 16'h10;
        n_fail = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        rows = '{'{2'h0, 1'b0, 4'h0, 8'ha5, 1'b0, 1'b0}, '{2'h1, 1'b0, 4'h1, 8'h3c, 1'b0, 1'b0},
                 '{2'h1, 1'b0, 4'h1, 8'h3d, 1'b1, 1'b1}, '{2'h2, 1'b0, 4'h2, 8'hc3, 1'b0, 1'b0},
                 '{2'h2, 1'b0, 4'h3, 8'h7e, 1'b1, 1'b1}, '{2'h3, 1'b0, 4'h0, 8'h5a, 1'b1, 1'b0},
                 '{2'h1, 1'b1, 4'h1, 8'h96, 1'b0, 1'b0}, '{2'h2, 1'b1, 4'h0, 8'h01, 1'b1, 1'b1}};
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, ADDR_MODE, 32'h0);
        `CHK("mode reset", 32'(MODE_RST), q)
        apb(1'b0, ADDR_BAUD, 32'h0);
        `CHK("baud reset", 32'(BAUD_RST), q)
        irq_is(1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            cfg(rows[i].code, rows[i].hs, rows[i].baud);
            send(rows[i].data, rows[i].flip);
            apb(1'b0, ADDR_RXBUF, 32'h0);
            `CHK("rxbuf", {23'h0, rows[i].parity_error_flag, rows[i].data}, q)
            apb(1'b0, ADDR_STATUS, 32'h0);
            `CHK("parity flag", rows[i].parity_error_flag, q[STA_PARITY_ERROR_FLAG_BIT])
            apb(1'b1, ADDR_STATUS, 32'he);
        end
        $display("test table done");
        cfg(2'h1, 1'b0, 4'h0);
        apb(1'b1, ADDR_IMASK, 32'h1 << IFL_P1_BIT);
        for (int k = 0; k < 4; k++) begin
            send(8'(8'h10 + k), 1'b0);
            apb(1'b0, ADDR_STATUS, 32'h0);
            `CHK("full", k == 3, q[STA_FULL_BIT])
            `CHK("overrun early", 1'b0, q[STA_OVR_BIT])
            apb(1'b0, ADDR_IFLAG, 32'h0);
            `CHK("rx flag", k == 3, q[IFL_P1_BIT])
        end
        irq_is(1'b1);
        apb(1'b1, ADDR_IMASK, 32'h0);
        irq_is(1'b0);
        apb(1'b1, ADDR_IMASK, 32'h1 << IFL_P1_BIT);
        send(8'h55, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("overrun", 1'b1, q[STA_OVR_BIT])
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, ADDR_RXBUF, 32'h0);
            `CHK("pop", 32'h10 + k, q)
        end
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("drained", 2'b10, {q[STA_OVR_BIT], q[STA_AVAIL_BIT]})
        apb(1'b0, ADDR_IFLAG, 32'h0);
        `CHK("flag held", 1'b1, q[IFL_P1_BIT])
        apb(1'b1, ADDR_STATUS, 32'h2);
        apb(1'b1, ADDR_IFLAG, 32'h1 << IFL_P1_BIT);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("overrun cleared", 1'b0, q[STA_OVR_BIT])
        irq_is(1'b0);
        $display("test fifo done");
        apb(1'b0, 12'h018, 32'h0);
        `CHK("unmapped error", 1'b1, e)
        `CHK("unmapped data", 32'h0, q)
        $display("test unmapped done");
        cfg(2'h2, 1'b0, 4'h1);
        send(8'h42, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("avail before reset", 1'b1, q[STA_AVAIL_BIT])
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status after reset", 32'h0, q)
        apb(1'b0, ADDR_MODE, 32'h0);
        `CHK("mode after reset", 32'(MODE_RST), q)
        irq_is(1'b0);
        $display("test mid reset done");
        wrap_up();
    end
endmodule
